// [pkg/jrx_regs.svh]
`ifndef JRX_REGS_SVH
`define JRX_REGS_SVH

// Register offsets
`define JRX_OFS_SYNC_MODE   15'h0104
`define JRX_OFS_KLEN        15'h0105
`define JRX_OFS_DELAY       15'h0106
`define JRX_OFS_STATUS      15'h0107

// Configuration reset values
`define JRX_SYNC_MODE_RESET 2'h0
`define JRX_KLEN_RESET      8'h1f
`define JRX_DELAY_RESET     6'h00

// Sync word mode encodings
`define JRX_MODE_CRC12      2'h0

// Status bit positions
`define JRX_ST_FAULT        7
`define JRX_ST_LINK_UP      6
`define JRX_ST_SYNC_LEVEL   5
`define JRX_ST_REALIGNED    4
`define JRX_ST_CONSISTENT   3
`define JRX_ST_PLL_LOCKED   2

// Serial frame: read flag, address, data
`define JRX_SPI_FRAME_BITS  5'h18
`define JRX_SPI_HDR_BITS    5'h10
`define JRX_SPI_RD_BIT      23

// CRC field in the sync word
`define JRX_SW_CRC_HI       11
`define JRX_SW_CRC_LO       0

// Octets per data word, as a shift
`define JRX_OCTET_SHIFT     2

`endif

// [pkg/jrx_pkg.sv]
package jrx_pkg;

  // Link bring-up states, one-hot
  typedef enum logic [2:0] {
    JRX_LNK_OFF  = 3'b001,
    JRX_LNK_WAIT = 3'b010,
    JRX_LNK_UP   = 3'b100
  } jrx_link_state_t;

  // Software-visible configuration
  typedef struct packed {
    logic [1:0] sync_word_mode_select;
    logic [7:0] frames_per_multiframe_minus_one;
    logic [5:0] release_delay_octets;
  } jrx_cfg_t;

endpackage

// [verilog/jrx_sync2.sv]
`timescale 1ns/1ps
`default_nettype none

module jrx_sync2
  import jrx_pkg::*;
#(
  parameter int WIDTH = 1
) (
  input  wire logic             clock_in,
  input  wire logic             reset_in,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  // Two flops; the first is read only by the second
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } jrx_sync_state_t;

  jrx_sync_state_t st_r;
  jrx_sync_state_t st_nxt;

  // Shift the pin level one stage per cycle
  always_comb begin
    st_nxt        = st_r;
    st_nxt.meta   = async_in;
    st_nxt.stable = st_r.meta;
  end

  // Register the state
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign sync_out = st_r.stable;

endmodule

`default_nettype wire

// [verilog/jrx_fifo.sv]
`timescale 1ns/1ps
`default_nettype none

module jrx_fifo
  import jrx_pkg::*;
#(
  parameter int WIDTH = 32,
  parameter int DEPTH = 32
) (
  input  wire logic             clock_in,
  input  wire logic             reset_in,
  input  wire logic             flush_in,
  input  wire logic             in_valid_in,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  in_ready_out,
  output logic                  out_valid_out,
  output logic      [WIDTH-1:0] out_data_out,
  input  wire logic             out_ready_in
);

  // Depth is a power of two so pointers wrap freely
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wptr;
    logic [AW-1:0]               rptr;
    logic [AW:0]                 count;
    logic                        ready;
  } jrx_fifo_state_t;

  jrx_fifo_state_t st_r;
  jrx_fifo_state_t st_nxt;
  logic            push;
  logic            pop;

  // Push and pop; ready is a flop
  always_comb begin
    st_nxt = st_r;
    push   = in_valid_in && st_r.ready;
    pop    = out_ready_in && (st_r.count != '0);
    if (flush_in) begin
      st_nxt.wptr  = '0;
      st_nxt.rptr  = '0;
      st_nxt.count = '0;
    end else begin
      if (push) begin
        st_nxt.mem[st_r.wptr] = in_data_in;
        st_nxt.wptr           = st_r.wptr + 1'b1;
      end
      if (pop) begin
        st_nxt.rptr = st_r.rptr + 1'b1;
      end
      if (push && !pop) begin
        st_nxt.count = st_r.count + 1'b1;
      end else if (pop && !push) begin
        st_nxt.count = st_r.count - 1'b1;
      end
    end
    st_nxt.ready = (st_nxt.count != (AW+1)'(DEPTH));
  end

  // Register the state
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      st_r       <= '0;
      st_r.ready <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign in_ready_out  = st_r.ready;
  assign out_valid_out = (st_r.count != '0);
  assign out_data_out  = st_r.mem[st_r.rptr];

endmodule

`default_nettype wire

// [verilog/jrx_link_regs.sv]
// What this block does
// R1: Mode zero enables CRC-12 sync word checking.
// R2: Sync word mode only acts in 64b/66b.
// R3: Command fields in sync word are ignored.
// R4: Settings change only while link disabled; the block accepts writes at any time.
// R5: Length field holds K minus one, reset 31.
// R6: Software programs only legal K values.
// R7: 64b/66b uses K equal 256*E/F.
// R8: Each delay step shifts release four octets.
// R9: Software keeps release delay legal.
// R10: Buffer underflow/overflow sets fault.
// R11: Writing one clears fault bit.
// R12: Link-up bit reads one once released.
// R13: Bit five shows the SYNC level.
// R14: SYSREF realign sets sticky bit.
// R15: Bit three shows last SYSREF phase consistent.
// R16: Consistency may take several SYSREF pulses.
// R17: SYSREF bits meaningless in subclass zero.
// R18: Bit two means all enabled PLLs locked.
// R19: Encoding select: zero 8b/10b, one 64b/66b.
// R20: Subclass one releases on shifted boundary.
// R21: Flags change only by events, clears.
`include "jrx_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module jrx_link_regs
  import jrx_pkg::*;
#(
  parameter int DATA_WIDTH = 32,
  parameter int FIFO_DEPTH = 32,
  parameter int PLL_COUNT  = 2
) (
  input  wire logic                  clock_in,
  input  wire logic                  reset_in,
  // Serial control port pins
  input  wire logic                  spi_clk_in,
  input  wire logic                  spi_sel_n_in,
  input  wire logic                  spi_data_in,
  output logic                       spi_data_out,
  // Link control
  input  wire logic                  link_enable_in,
  input  wire logic                  link_encoding_select_in,
  input  wire logic                  subclass_select_in,
  input  wire logic [4:0]            frame_octets_in,
  input  wire logic [4:0]            multiblocks_in,
  input  wire logic                  lanes_synced_in,
  // SYSREF and PLL lock pins
  input  wire logic                  sysref_in,
  input  wire logic [PLL_COUNT-1:0]  pll_lock_in,
  input  wire logic [PLL_COUNT-1:0]  pll_enable_in,
  // Sync words and local CRC
  input  wire logic                  sync_word_valid_in,
  input  wire logic [31:0]           sync_word_in,
  input  wire logic [11:0]           crc_calc_in,
  // Lane data in
  input  wire logic                  lane_valid_in,
  input  wire logic [DATA_WIDTH-1:0] lane_data_in,
  output logic                       lane_ready_out,
  // Released data
  output logic                       data_valid_out,
  output logic [DATA_WIDTH-1:0]      data_out,
  input  wire logic                  data_ready_in,
  // Link indications
  output logic                       sync_request_n_out,
  output logic                       link_up_out,
  output logic                       crc_check_enable_out,
  output logic                       crc_error_out
);

  // Whole block state
  typedef struct packed {
    jrx_link_state_t        link;        // Bring-up state
    jrx_cfg_t               cfg;         // Software settings
    logic                   fault;       // Elastic buffer fault, sticky
    logic                   realigned;   // SYSREF realign event, sticky
    logic                   consistent;  // Last SYSREF matched phase
    logic                   pll_ok;      // All enabled PLLs locked
    logic                   sync_level;  // One while SYNC de-asserted
    logic [11:0]            lmfc;        // Word position in multiframe
    logic                   sysref_d;    // Previous SYSREF sample
    logic                   sclk_d;      // Previous serial clock sample
    logic [4:0]             bitcnt;      // Serial bits received
    logic [23:0]            shin;        // Serial shift-in register
    logic [7:0]             shout;       // Serial read data
    logic                   sdo;         // Serial output bit
    logic                   out_valid;   // Output stage full
    logic [DATA_WIDTH-1:0]  out_data;    // Output stage word
    logic                   crc_en;      // CRC checking active
    logic                   crc_err;     // CRC mismatch pulse
  } jrx_top_state_t;

  jrx_top_state_t        st_r;
  jrx_top_state_t        st_nxt;

  logic                  spi_clk_s;      // Synchronised pins
  logic                  spi_sel_n_s;
  logic                  spi_data_s;
  logic                  sysref_s;
  logic [PLL_COUNT-1:0]  pll_lock_s;

  logic                  fifo_ready;     // Buffer accepts a word
  logic                  fifo_valid;     // Buffer holds a word
  logic [DATA_WIDTH-1:0] fifo_data;      // Oldest buffered word
  logic                  fifo_pop;       // Move a word to the output

  logic [13:0]           k_times_f;      // Octets per multiframe
  logic [11:0]           period_words;   // Words per multiframe
  logic                  sysref_rise;
  logic                  release_opp;
  logic                  underflow;
  logic                  overflow;
  logic                  sclk_rise;
  logic                  sclk_fall;
  logic [23:0]           frame;
  logic                  wr_en;
  logic [14:0]           wr_addr;
  logic [7:0]            wr_data;

  // Asynchronous pins pass two flops
  jrx_sync2 #(
    .WIDTH (4 + PLL_COUNT)
  ) u_sync (
    .clock_in (clock_in),
    .reset_in (reset_in),
    .async_in ({spi_clk_in, spi_sel_n_in, spi_data_in, sysref_in, pll_lock_in}),
    .sync_out ({spi_clk_s, spi_sel_n_s, spi_data_s, sysref_s, pll_lock_s})
  );

  // Elastic buffer; flushed while the link is off
  jrx_fifo #(
    .WIDTH (DATA_WIDTH),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clock_in      (clock_in),
    .reset_in      (reset_in),
    .flush_in      (!link_enable_in),
    .in_valid_in   (lane_valid_in),
    .in_data_in    (lane_data_in),
    .in_ready_out  (fifo_ready),
    .out_valid_out (fifo_valid),
    .out_data_out  (fifo_data),
    .out_ready_in  (fifo_pop)
  );

  // Register read multiplexer; unmapped addresses read zero
  function automatic logic [7:0] read_mux(input logic [14:0] addr, input jrx_top_state_t s);
    logic [7:0] d;
    d = 8'h00;
    unique case (addr)
      `JRX_OFS_SYNC_MODE: begin
        d[1:0] = s.cfg.sync_word_mode_select;
      end
      `JRX_OFS_KLEN: begin
        d = s.cfg.frames_per_multiframe_minus_one;
      end
      `JRX_OFS_DELAY: begin
        d[5:0] = s.cfg.release_delay_octets;
      end
      `JRX_OFS_STATUS: begin
        d[`JRX_ST_FAULT]      = s.fault; // R10
        d[`JRX_ST_LINK_UP]    = s.link[2]; // R12
        d[`JRX_ST_SYNC_LEVEL] = s.sync_level; // R13
        d[`JRX_ST_REALIGNED]  = s.realigned; // R14
        d[`JRX_ST_CONSISTENT] = s.consistent; // R15
        d[`JRX_ST_PLL_LOCKED] = s.pll_ok; // R18
      end
      default: begin
        d = 8'h00;
      end
    endcase
    return d;
  endfunction

  // Multiframe length in words; 64b/66b uses 256*E octets
  always_comb begin
    k_times_f = ({6'h00, st_r.cfg.frames_per_multiframe_minus_one} + 14'h0001)
                * {9'h000, frame_octets_in}; // R5
    if (link_encoding_select_in) begin // R19
      period_words = {1'b0, multiblocks_in, 6'h00}; // R7
    end else begin
      period_words = 12'(k_times_f >> `JRX_OCTET_SHIFT);
    end
    if (period_words == 12'h000) begin
      period_words = 12'h001;  // Guards against a zero F or E setting
    end
  end

  // Main next-state logic
  always_comb begin
    st_nxt      = st_r;
    frame       = {st_r.shin[22:0], spi_data_s};
    sclk_rise   = spi_clk_s && !st_r.sclk_d;
    sclk_fall   = !spi_clk_s && st_r.sclk_d;
    sysref_rise = sysref_s && !st_r.sysref_d;
    wr_en       = 1'b0;
    wr_addr     = frame[22:8];
    wr_data     = frame[7:0];

    st_nxt.sclk_d   = spi_clk_s;
    st_nxt.sysref_d = sysref_s;

    // Serial port: frame is read flag, address, then data, MSB first
    if (spi_sel_n_s) begin
      st_nxt.bitcnt = 5'h00;
      st_nxt.sdo    = 1'b0;
    end else begin
      if (sclk_rise && (st_r.bitcnt != `JRX_SPI_FRAME_BITS)) begin
        st_nxt.shin   = frame;
        st_nxt.bitcnt = st_r.bitcnt + 5'h01;
        // Read data fetched once the address is in
        if (st_r.bitcnt == (`JRX_SPI_HDR_BITS - 5'h01)) begin
          st_nxt.shout = read_mux(frame[14:0], st_r);
        end
        // A write lands on the last data bit
        if ((st_r.bitcnt == (`JRX_SPI_FRAME_BITS - 5'h01)) && !frame[`JRX_SPI_RD_BIT]) begin
          wr_en = 1'b1;
        end
      end
      // Read data leaves on falling edges during the data phase only
      if (sclk_fall && (st_r.bitcnt >= `JRX_SPI_HDR_BITS)
          && st_r.shin[5'(st_r.bitcnt - 5'h01)]) begin
        st_nxt.sdo   = st_r.shout[7];
        st_nxt.shout = {st_r.shout[6:0], 1'b0};
      end
    end

    // Writes act at once; software holds them while linked
    if (wr_en) begin
      unique case (wr_addr)
        `JRX_OFS_SYNC_MODE: begin
          st_nxt.cfg.sync_word_mode_select = wr_data[1:0];
        end
        `JRX_OFS_KLEN: begin
          st_nxt.cfg.frames_per_multiframe_minus_one = wr_data; // R5
        end
        `JRX_OFS_DELAY: begin
          st_nxt.cfg.release_delay_octets = wr_data[5:0]; // R8
        end
        `JRX_OFS_STATUS: begin
          // Write-one clears; the hardware set below still wins
          if (wr_data[`JRX_ST_FAULT]) begin
            st_nxt.fault = 1'b0; // R11
          end
          if (wr_data[`JRX_ST_REALIGNED]) begin
            st_nxt.realigned = 1'b0; // R14
          end
        end
        default: begin
          st_nxt.cfg = st_r.cfg;
        end
      endcase
    end

    // CRC-12 check of the sync word only in 64b/66b with mode zero
    st_nxt.crc_en  = link_encoding_select_in
                     && (st_r.cfg.sync_word_mode_select == `JRX_MODE_CRC12); // R1 R2
    st_nxt.crc_err = 1'b0;
    if (st_r.crc_en && sync_word_valid_in) begin
      // Only the CRC field is compared; command bits ignored
      st_nxt.crc_err = (sync_word_in[`JRX_SW_CRC_HI:`JRX_SW_CRC_LO] != crc_calc_in); // R1 R3
    end

    // Multiframe word counter; cleared while link is off
    if (!link_enable_in) begin
      st_nxt.lmfc = 12'h000;
    end else if (st_r.lmfc >= (period_words - 12'h001)) begin
      st_nxt.lmfc = 12'h000;
    end else begin
      st_nxt.lmfc = st_r.lmfc + 12'h001;
    end

    // SYSREF phase check; unused in subclass zero
    if (link_enable_in && subclass_select_in && sysref_rise) begin // R17
      st_nxt.consistent = (st_r.lmfc == 12'h000); // R15
      if (st_r.lmfc != 12'h000) begin
        // Out of phase: pull the counter onto SYSREF and flag it.
        // Consistency may need several pulses.
        st_nxt.lmfc      = 12'h001;
        st_nxt.realigned = 1'b1; // R14 R16
      end
    end

    // Release opportunity: boundary shifted by delay, one word per step
    release_opp = (st_r.lmfc == {6'h00, st_r.cfg.release_delay_octets});    // R8 R20

    // Link bring-up
    unique case (st_r.link)
      JRX_LNK_OFF: begin
        if (link_enable_in) begin
          st_nxt.link = JRX_LNK_WAIT;
        end
      end
      JRX_LNK_WAIT: begin
        if (!link_enable_in) begin
          st_nxt.link = JRX_LNK_OFF;
        end else if (fifo_valid && lanes_synced_in
                     && (!subclass_select_in || release_opp)) begin // R20
          st_nxt.link = JRX_LNK_UP; // R12
        end
      end
      JRX_LNK_UP: begin
        if (!link_enable_in) begin
          st_nxt.link = JRX_LNK_OFF;
        end
      end
      default: begin
        st_nxt.link = JRX_LNK_OFF;
      end
    endcase

    // Output stage drains the buffer once released
    fifo_pop  = st_r.link[2] && (!st_r.out_valid || data_ready_in);
    underflow = fifo_pop && !fifo_valid;
    overflow  = lane_valid_in && !fifo_ready;
    if (!link_enable_in) begin
      st_nxt.out_valid = 1'b0;
    end else if (fifo_pop && fifo_valid) begin
      st_nxt.out_valid = 1'b1;
      st_nxt.out_data  = fifo_data;
    end else if (data_ready_in) begin
      st_nxt.out_valid = 1'b0;
    end

    // Buffer fault is sticky; a set in the clear cycle wins
    if (underflow || overflow) begin
      st_nxt.fault = 1'b1; // R10 R21
    end

    // Live status levels
    st_nxt.sync_level = link_enable_in && lanes_synced_in; // R13
    st_nxt.pll_ok     = &(pll_lock_s | ~pll_enable_in); // R18
  end

  // Register the state; status flags reset to zero
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      st_r <= '0;
      st_r.link <= JRX_LNK_OFF;
      st_r.cfg.sync_word_mode_select <= `JRX_SYNC_MODE_RESET;
      st_r.cfg.frames_per_multiframe_minus_one <= `JRX_KLEN_RESET; // R5
      st_r.cfg.release_delay_octets <= `JRX_DELAY_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from flops
  assign spi_data_out         = st_r.sdo;
  assign lane_ready_out       = fifo_ready;
  assign data_valid_out       = st_r.out_valid;
  assign data_out             = st_r.out_data;
  assign sync_request_n_out   = st_r.sync_level;
  assign link_up_out          = st_r.link[2];
  assign crc_check_enable_out = st_r.crc_en;
  assign crc_error_out        = st_r.crc_err;

endmodule

`default_nettype wire

// [testbench/jrx_link_regs_props.sv]
`timescale 1ns/1ps
`default_nettype none
module jrx_link_regs_props
  import jrx_pkg::*;
(
  input wire logic        clock_in,
  input wire logic        reset_in,
  input wire logic        link_enable_in,
  input wire logic        link_encoding_select_in,
  input wire logic        lanes_synced_in,
  input wire logic        sync_word_valid_in,
  input wire logic [31:0] sync_word_in,
  input wire logic [11:0] crc_calc_in,
  input wire logic        data_valid_out,
  input wire logic        sync_request_n_out,
  input wire logic        link_up_out,
  input wire logic        crc_check_enable_out,
  input wire logic        crc_error_out
);
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (reset_in);
  // Sync word check field mismatch
  wire logic crc_bad = sync_word_in[11:0] != crc_calc_in;
  a_crc_needs_66b: assert property (
    crc_check_enable_out |-> $past(link_encoding_select_in))
    else $error("crc on outside 64b/66b");
  a_crc_err_cause: assert property (
    crc_error_out |-> $past(sync_word_valid_in && crc_bad))
    else $error("crc error without cause");
  a_crc_err_flag: assert property (
    sync_word_valid_in && crc_check_enable_out && crc_bad |=> crc_error_out)
    else $error("bad sync word not flagged");
  a_cmd_bits_free: assert property (
    sync_word_valid_in && !crc_bad |=> !crc_error_out)
    else $error("good sync word flagged");
  a_crc_off_8b10b: assert property (
    sync_word_valid_in && !link_encoding_select_in |=> !crc_error_out)
    else $error("crc error in 8b/10b");
  // Skip the cycle after reset
  a_sync_level: assert property (
    !$past(reset_in) |-> sync_request_n_out == $past(link_enable_in && lanes_synced_in))
    else $error("sync level wrong");
  a_link_drop: assert property (!link_enable_in |=> !link_up_out)
    else $error("link up while disabled");
  a_data_after_up: assert property ($rose(data_valid_out) |-> $past(link_up_out))
    else $error("data before link up");
  a_up_needs_lanes: assert property (
    $rose(link_up_out) |-> $past(lanes_synced_in) || $past(lanes_synced_in, 2))
    else $error("link up without lane lock");
  c_crc_error: cover property (crc_error_out);
  c_link_up: cover property ($rose(link_up_out));
  c_sync_release: cover property ($rose(sync_request_n_out));
endmodule

bind jrx_link_regs jrx_link_regs_props jrx_link_regs_props_inst (
  .clock_in(clock_in), .reset_in(reset_in), .link_enable_in(link_enable_in),
  .link_encoding_select_in(link_encoding_select_in), .lanes_synced_in(lanes_synced_in),
  .sync_word_valid_in(sync_word_valid_in), .sync_word_in(sync_word_in),
  .crc_calc_in(crc_calc_in), .data_valid_out(data_valid_out),
  .sync_request_n_out(sync_request_n_out), .link_up_out(link_up_out),
  .crc_check_enable_out(crc_check_enable_out), .crc_error_out(crc_error_out));
`default_nettype wire

// [testbench/jrx_tx_model.sv]
`timescale 1ns/1ps
`default_nettype none
module jrx_tx_model
  import jrx_pkg::*;
(
  input  wire logic  clock_in,
  input  wire logic  reset_in,
  input  wire logic  sync_n_in,  // High lets payload flow
  input  wire logic  send_in,    // Bench allows payload
  input  wire logic  slow_in,    // Idle every other cycle
  input  wire logic  sw_send_in, // Emit one sync word
  input  wire logic  sw_bad_in,  // Corrupt the local CRC
  input  wire logic  ready_in,
  output logic        valid_out,
  output logic [31:0] data_out,
  output logic        sw_valid_out,
  output logic [31:0] sw_out,
  output logic [11:0] crc_out
);
  logic [31:0] word_r; // Next payload word
  logic        gap_r;  // Pacing toggle
  // Hold payload until taken; idle data toggles
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      word_r <= 32'h0000_0000;
      gap_r <= 1'b0;
      valid_out <= 1'b0;
      data_out <= 32'hffff_ffff;
      sw_valid_out <= 1'b0;
    end else begin
      gap_r <= slow_in & ~gap_r;
      sw_valid_out <= sw_send_in;
      sw_out <= {word_r[19:0], word_r[11:0]};
      crc_out <= word_r[11:0] ^ {11'h000, sw_bad_in};
      if (valid_out && ready_in) begin
        word_r <= word_r + 32'h0000_0001;
      end
      if (valid_out && !ready_in) begin
        valid_out <= 1'b1;
      end else if (sync_n_in && send_in && !gap_r) begin
        valid_out <= 1'b1;
        data_out <= (valid_out && ready_in) ? word_r + 32'h0000_0001 : word_r;
      end else begin
        valid_out <= 1'b0;
        data_out <= ~data_out;
      end
    end
  end
endmodule
`default_nettype wire

// [testbench/jrx_link_regs_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
`include "jrx_regs.svh"
module jrx_link_regs_tb_top
  import jrx_pkg::*;
;
  logic        clock_in, reset_in, spi_clk, spi_sel_n, spi_mosi, spi_miso;
  logic        link_en, enc_sel, subclass, lanes_synced, sysref, data_ready;
  logic        lane_valid, lane_ready, data_valid, sync_n, link_up, crc_en, crc_err;
  logic        sw_valid, send, slow, sw_send, sw_bad;
  logic [1:0]  pll_lock, pll_en;
  logic [31:0] lane_data, data_word, sw_word;
  logic [11:0] crc_calc;
  int          miscompares, check_count;

  jrx_link_regs jrx_link_regs_inst (
    .clock_in(clock_in), .reset_in(reset_in), .spi_clk_in(spi_clk), .spi_sel_n_in(spi_sel_n),
    .spi_data_in(spi_mosi), .spi_data_out(spi_miso), .link_enable_in(link_en),
    .link_encoding_select_in(enc_sel), .subclass_select_in(subclass),
    .frame_octets_in(5'h04), .multiblocks_in(5'h01), .lanes_synced_in(lanes_synced),
    .sysref_in(sysref), .pll_lock_in(pll_lock), .pll_enable_in(pll_en),
    .sync_word_valid_in(sw_valid), .sync_word_in(sw_word), .crc_calc_in(crc_calc),
    .lane_valid_in(lane_valid), .lane_data_in(lane_data), .lane_ready_out(lane_ready),
    .data_valid_out(data_valid), .data_out(data_word), .data_ready_in(data_ready),
    .sync_request_n_out(sync_n), .link_up_out(link_up), .crc_check_enable_out(crc_en),
    .crc_error_out(crc_err));

  jrx_tx_model jrx_tx_model_inst (
    .clock_in(clock_in), .reset_in(reset_in), .sync_n_in(sync_n), .send_in(send),
    .slow_in(slow), .sw_send_in(sw_send), .sw_bad_in(sw_bad), .ready_in(lane_ready),
    .valid_out(lane_valid), .data_out(lane_data), .sw_valid_out(sw_valid),
    .sw_out(sw_word), .crc_out(crc_calc));

  // 50 MHz clock
  initial begin
    clock_in = 1'b0;
    forever #10 clock_in = ~clock_in;
  end

  // Inputs move 1 ns after the edge
  task automatic cyc(input int n);
    repeat (n) @(posedge clock_in);
    #1;
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t register %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_pin(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t port %h expected %h", $time, got, exp);
    end
  endtask

  // Bounded wait; timeout ends the run
  task automatic wait_for(ref logic s, input logic v, input int lim);
    for (int i = 0; i < lim && s !== v; i++) cyc(1);
    if (s !== v) begin
      miscompares++;
      $display("BAD %0t wait ran out", $time);
      test_done;
    end
  endtask

  // One 24-bit frame; 5-clock half periods
  task automatic spi(input logic r, input logic [14:0] a, input logic [7:0] d,
                     output logic [7:0] q);
    logic [23:0] f;
    f = {r, a, d};
    spi_sel_n = 1'b0;
    cyc(5);
    for (int i = 23; i >= 0; i--) begin
      spi_clk = 1'b0;
      spi_mosi = f[i];
      cyc(5);
      if (i < 8) q[i] = spi_miso;
      spi_clk = 1'b1;
      cyc(5);
    end
    spi_clk = 1'b0;
    spi_sel_n = 1'b1;
    cyc(5);
  endtask

  task automatic wr(input logic [14:0] a, input logic [7:0] d);
    logic [7:0] q;
    spi(1'b0, a, d, q);
  endtask

  task automatic rd_chk(input logic [14:0] a, input logic [7:0] m, input logic [7:0] e);
    logic [7:0] q;
    spi(1'b1, a, 8'h00, q);
    chk_reg(q & m, e);
  endtask

  task automatic t_regs;
    rd_chk(`JRX_OFS_SYNC_MODE, 8'hff, 8'h00);
    rd_chk(`JRX_OFS_KLEN, 8'hff, 8'h1f);
    rd_chk(`JRX_OFS_DELAY, 8'hff, 8'h00);
    wr(`JRX_OFS_SYNC_MODE, 8'hff);
    rd_chk(`JRX_OFS_SYNC_MODE, 8'hff, 8'h03);
    wr(`JRX_OFS_DELAY, 8'hff);
    rd_chk(`JRX_OFS_DELAY, 8'hff, 8'h3f);
    wr(15'h0110, 8'h55);
    rd_chk(15'h0110, 8'hff, 8'h00);
    wr(`JRX_OFS_DELAY, 8'h00);
    $display("t_regs done");
  endtask

  // All encoding/check pairings
  task automatic t_crc;
    logic seen;
    enc_sel = 1'b1;
    cyc(3);
    chk_pin(crc_en, 0);
    wr(`JRX_OFS_SYNC_MODE, 8'h00);
    for (int k = 0; k < 4; k++) begin
      enc_sel = k[1];
      sw_bad = k[0];
      cyc(3);
      chk_pin(crc_en, k[1]);
      sw_send = 1'b1;
      cyc(1);
      sw_send = 1'b0;
      seen = 1'b0;
      repeat (4) begin
        cyc(1);
        seen = seen | crc_err;
      end
      chk_pin(seen, k[1] & k[0]);
    end
    enc_sel = 1'b0;
    $display("t_crc done");
  endtask

  task automatic t_pll;
    logic [3:0] tbl [3] = '{4'b1101, 4'b1111, 4'b0101};
    for (int k = 0; k < 3; k++) begin
      pll_en = tbl[k][3:2];
      pll_lock = tbl[k][1:0];
      cyc(4);
      rd_chk(`JRX_OFS_STATUS, 8'h07, {5'h00, &(tbl[k][1:0] | ~tbl[k][3:2]), 2'b00});
    end
    $display("t_pll done");
  endtask

  // Overfill, then drain a slow sender to underflow
  task automatic t_link;
    data_ready = 1'b0;
    send = 1'b1;
    link_en = 1'b1;
    lanes_synced = 1'b1;
    wait_for(link_up, 1'b1, 200);
    wait_for(lane_ready, 1'b0, 200);
    rd_chk(`JRX_OFS_STATUS, 8'he0, 8'he0);
    slow = 1'b1;
    data_ready = 1'b1;
    for (int w = 0; w < 40; w++) begin
      wait_for(data_valid, 1'b1, 20);
      chk_pin(data_word, w);
      cyc(1);
    end
    cyc(40);
    link_en = 1'b0;
    cyc(4);
    rd_chk(`JRX_OFS_STATUS, 8'he0, 8'h80);
    wr(`JRX_OFS_STATUS, 8'h00);
    rd_chk(`JRX_OFS_STATUS, 8'h80, 8'h80);
    wr(`JRX_OFS_STATUS, 8'h80);
    rd_chk(`JRX_OFS_STATUS, 8'h80, 8'h00);
    send = 1'b0;
    $display("t_link done");
  endtask

  task automatic sref;
    sysref = 1'b1;
    cyc(1);
    sysref = 1'b0;
  endtask

  // 8-word period: two late edges realign, the third agrees
  task automatic t_sysref;
    subclass = 1'b1;
    wr(`JRX_OFS_KLEN, 8'h07);
    link_en = 1'b1;
    cyc(5);
    sref;
    cyc(2);
    sref;
    cyc(15);
    sref;
    cyc(10);
    rd_chk(`JRX_OFS_STATUS, 8'h18, 8'h18);
    wr(`JRX_OFS_STATUS, 8'h18);
    rd_chk(`JRX_OFS_STATUS, 8'h18, 8'h08);
    link_en = 1'b0;
    $display("t_sysref done");
  endtask

  initial begin
    miscompares = 0;
    check_count = 0;
    {reset_in, spi_sel_n} = 2'b11;
    {spi_clk, spi_mosi, link_en, enc_sel, subclass, lanes_synced, sysref} = 7'h00;
    {data_ready, send, slow, sw_send, sw_bad, pll_lock, pll_en} = 9'h000;
    repeat (6) @(posedge clock_in);
    #1;
    reset_in = 1'b0;
    cyc(4);
    t_regs;
    t_crc;
    t_pll;
    t_link;
    t_sysref;
    test_done;
  end
endmodule
`default_nettype wire
